/* File: src/pcg_ctrl.sv */
// Power and clock gating controller: master clock selection and prescaler, processor
// sleep gating, USB clock gate, per-peripheral gates and asynchronous partial wake-up.
// Assumes core, interrupt and wait-mode signals are on clk; peripheral requests and
// source-ready levels are asynchronous and synchronised here.
// How it works
// - Reset selects main RC clock at 4 MHz
// - Source select plus power-of-two or three prescaler
// - Config write clears ready until clock runs
// - Wait instructions stop core clock when low-power clear
// - Core clock on after reset, interrupt re-enables
// - Current instruction finishes; other masters keep running
// - Tick calibration reads constant 37500
// - USB source select and divider setting
// - USB clock enabled, disabled, status readable
// - USB needs USB clock and peripheral clock
// - Peripheral clock enable, disable, status registers
// - Disable stops at once; all off after reset
// - Bit position equals peripheral identifier
// - Wait mode clocks only requesting peripheral
// - Wake request wakes system, else clock stops
// - Wake request turns partial wake-up off
// - Active mode: armed peripheral clocked on request
// - Active wake request disarms, clock stays on
// - Withdrawn request stops clock until reasserted
`timescale 1ns/1ps

module pcg_ctrl
    import pcg_pkg::*;
#(
    parameter int NUM_PERIPH = 32,
    parameter int SWITCH_CYCLES = pcg_pkg::MCLK_SWITCH_CYCLES
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic [3:0] source_ready_async,
    input wire logic core_wfi,
    input wire logic core_wfe,
    input wire logic core_instr_done,
    input wire logic irq_wake,
    input wire logic wait_mode,
    input wire logic [NUM_PERIPH-1:0] periph_clk_req_async,
    input wire logic [NUM_PERIPH-1:0] periph_wake_req_async,
    output pcg_pkg::pcg_mclk_cfg_t master_clock_cfg,
    output logic [1:0] main_rc_freq_sel,
    output logic master_clock_tick,
    output logic master_clock_ready,
    output logic cpu_clock_en,
    output logic bus_clock_en,
    output pcg_pkg::pcg_usb_cfg_t usb_cfg,
    output logic usb_clock_en,
    output logic [NUM_PERIPH-1:0] periph_clock_en,
    output logic system_wake
);
    // Refuse sizes that the 32-bit register words and the 8-bit switch counter cannot hold
    if (NUM_PERIPH < 1 || NUM_PERIPH > 32)
    begin
        $error("pcg_ctrl: NUM_PERIPH must be 1 to 32");
    end
    if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > 255)
    begin
        $error("pcg_ctrl: SWITCH_CYCLES must be 1 to 255");
    end

    // ****************************************
    // Synchronisers for asynchronous inputs
    // ****************************************
    logic [3:0] src_meta_reg;
    logic [3:0] src_sync_reg;
    logic [NUM_PERIPH-1:0] req_meta_reg;
    logic [NUM_PERIPH-1:0] req_sync_reg;
    logic [NUM_PERIPH-1:0] wake_meta_reg;
    logic [NUM_PERIPH-1:0] wake_sync_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            src_meta_reg <= '0;
            src_sync_reg <= '0;
            req_meta_reg <= '0;
            req_sync_reg <= '0;
            wake_meta_reg <= '0;
            wake_sync_reg <= '0;
        end
        else
        begin
            src_meta_reg <= source_ready_async;
            src_sync_reg <= src_meta_reg;
            req_meta_reg <= periph_clk_req_async;
            req_sync_reg <= req_meta_reg;
            wake_meta_reg <= periph_wake_req_async;
            wake_sync_reg <= wake_meta_reg;
        end
    end

    // ****************************************
    // Register decode
    // ****************************************
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr[7:2] == ofs[7:2]);
    endfunction

    wire wr_sys_en = reg_write && hit(reg_addr, OFS_SYS_CLK_EN);
    wire wr_sys_dis = reg_write && hit(reg_addr, OFS_SYS_CLK_DIS);
    wire wr_per_en = reg_write && hit(reg_addr, OFS_PER_CLK_EN);
    wire wr_per_dis = reg_write && hit(reg_addr, OFS_PER_CLK_DIS);
    wire wr_mclk = reg_write && hit(reg_addr, OFS_MCLK_CFG);
    wire wr_usb = reg_write && hit(reg_addr, OFS_USB_CFG);
    wire wr_fast = reg_write && hit(reg_addr, OFS_FAST_START);
    wire wr_pw_en = reg_write && hit(reg_addr, OFS_PW_EN);
    wire wr_pw_dis = reg_write && hit(reg_addr, OFS_PW_DIS);
    wire [NUM_PERIPH-1:0] wdata_bits = reg_wdata[NUM_PERIPH-1:0];

    // ****************************************
    // Master clock selection and prescaler
    // ****************************************
    pcg_mclk_cfg_t mclk_cfg_reg;
    logic mclk_ready_reg;
    logic [7:0] switch_cnt_reg;
    logic [6:0] div_cnt_reg;
    logic tick_reg;

    wire pcg_mclk_cfg_t mclk_cfg_next = wr_mclk ?
        pcg_mclk_cfg_t'{src_sel: reg_wdata[SRC_SEL_LSB +: 2], div_sel: reg_wdata[DIV_SEL_LSB +: 3]} :
        mclk_cfg_reg;
    wire [6:0] div_last = (mclk_cfg_reg.div_sel == DIV_SEL_DIV3) ? 7'h02 :
        7'((8'h01 << mclk_cfg_reg.div_sel) - 8'h01);
    wire sel_src_ready = src_sync_reg[mclk_cfg_reg.src_sel];
    wire switch_done = (switch_cnt_reg == 8'h00);
    wire [7:0] switch_cnt_next = wr_mclk ? 8'(SWITCH_CYCLES) :
        (switch_done ? 8'h00 : switch_cnt_reg - 8'h01);
    // A write always restarts the switch, so the clear takes priority here
    wire mclk_ready_next = wr_mclk ? 1'b0 : (mclk_ready_reg | (switch_done & sel_src_ready));
    wire div_wrap = (div_cnt_reg >= div_last);
    wire [6:0] div_cnt_next = (wr_mclk || div_wrap) ? 7'h00 : div_cnt_reg + 7'h01;
    // Tick only once the new clock is established, so no short period leaks out
    wire tick_next = div_wrap && mclk_ready_reg && !wr_mclk;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            mclk_cfg_reg <= MCLK_CFG_RESET;
            mclk_ready_reg <= 1'b0;
            switch_cnt_reg <= 8'(SWITCH_CYCLES);
            div_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            mclk_cfg_reg <= mclk_cfg_next;
            mclk_ready_reg <= mclk_ready_next;
            switch_cnt_reg <= switch_cnt_next;
            div_cnt_reg <= div_cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign master_clock_cfg = mclk_cfg_reg;
    assign main_rc_freq_sel = RC_FREQ_4MHZ;
    assign master_clock_tick = tick_reg;
    assign master_clock_ready = mclk_ready_reg;

    // ****************************************
    // Processor clock and sleep
    // ****************************************
    logic low_power_reg;
    logic sleep_pending_reg;
    logic cpu_en_reg;

    wire sleep_req = (core_wfi || core_wfe) && !low_power_reg;
    // Interrupt wins over a sleep that would start in the same cycle
    wire sleep_pending_next = irq_wake ? 1'b0 :
        ((sleep_pending_reg || sleep_req) && !(cpu_en_reg == 1'b0));
    wire cpu_en_next = irq_wake ? 1'b1 :
        ((sleep_pending_reg || sleep_req) && core_instr_done ? 1'b0 : cpu_en_reg);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            low_power_reg <= 1'b0;
            sleep_pending_reg <= 1'b0;
            cpu_en_reg <= 1'b1;
        end
        else
        begin
            low_power_reg <= wr_fast ? reg_wdata[LOW_POWER_POS] : low_power_reg;
            sleep_pending_reg <= sleep_pending_next;
            cpu_en_reg <= cpu_en_next;
        end
    end

    // Wait mode stops the core too; the sleep state itself is kept for the return
    assign cpu_clock_en = cpu_en_reg && !wait_mode;
    // Bus clock is never gated by sleep so other masters keep transferring
    assign bus_clock_en = !wait_mode;

    // ****************************************
    // USB clock
    // ****************************************
    pcg_usb_cfg_t usb_cfg_reg;
    logic usb_on_reg;

    wire usb_on_next = (usb_on_reg || (wr_sys_en && reg_wdata[USB_CLOCK_BIT_POS])) &&
        !(wr_sys_dis && reg_wdata[USB_CLOCK_BIT_POS]);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            usb_cfg_reg <= '0;
            usb_on_reg <= 1'b0;
        end
        else
        begin
            usb_cfg_reg <= wr_usb ? pcg_usb_cfg_t'{usb_sel: reg_wdata[USB_SEL_POS],
                usb_div: reg_wdata[USB_DIV_LSB +: 4]} : usb_cfg_reg;
            usb_on_reg <= usb_on_next;
        end
    end

    assign usb_cfg = usb_cfg_reg;
    // The USB port also needs its own peripheral gate from the vector below
    assign usb_clock_en = usb_on_reg && !wait_mode;

    // ****************************************
    // Peripheral gates and partial wake-up
    // ****************************************
    logic [NUM_PERIPH-1:0] per_on_reg;
    logic [NUM_PERIPH-1:0] pw_en_reg;
    logic wake_reg;

    // Bit n of every vector is peripheral identifier n
    wire [NUM_PERIPH-1:0] per_on_next = (per_on_reg | (wr_per_en ? wdata_bits : '0)) &
        ~(wr_per_dis ? wdata_bits : '0);
    wire [NUM_PERIPH-1:0] wake_hit = wake_sync_reg & pw_en_reg;
    // A wake event beats a software enable in the same cycle
    wire [NUM_PERIPH-1:0] pw_en_next = ((pw_en_reg | (wr_pw_en ? wdata_bits : '0)) &
        ~(wr_pw_dis ? wdata_bits : '0)) & ~wake_hit;
    wire [NUM_PERIPH-1:0] armed_clk = pw_en_reg & (req_sync_reg | wake_sync_reg);
    wire [NUM_PERIPH-1:0] plain_clk = ~pw_en_reg & {NUM_PERIPH{!wait_mode}};
    wire [NUM_PERIPH-1:0] activity = req_sync_reg & pw_en_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            per_on_reg <= '0;
            pw_en_reg <= '0;
            wake_reg <= 1'b0;
        end
        else
        begin
            per_on_reg <= per_on_next;
            pw_en_reg <= pw_en_next;
            wake_reg <= |wake_hit;
        end
    end

    // Combinational gate so a disable or withdrawn request stops the clock at once
    assign periph_clock_en = per_on_reg & (armed_clk | plain_clk);
    assign system_wake = wake_reg;

    // ****************************************
    // Read path
    // ****************************************
    function automatic logic [31:0] widen(input logic [NUM_PERIPH-1:0] v);
        widen = 32'(v);
    endfunction

    wire [31:0] mclk_word = (32'(mclk_cfg_reg.src_sel) << SRC_SEL_LSB) |
        (32'(mclk_cfg_reg.div_sel) << DIV_SEL_LSB);
    wire [31:0] usb_word = (32'(usb_cfg_reg.usb_sel) << USB_SEL_POS) |
        (32'(usb_cfg_reg.usb_div) << USB_DIV_LSB);
    wire [31:0] read_mux =
        hit(reg_addr, OFS_SYS_CLK_STAT) ? (32'(usb_on_reg) << USB_CLOCK_BIT_POS) :
        hit(reg_addr, OFS_PER_CLK_STAT) ? widen(per_on_reg) :
        hit(reg_addr, OFS_MCLK_CFG) ? mclk_word :
        hit(reg_addr, OFS_USB_CFG) ? usb_word :
        hit(reg_addr, OFS_FAST_START) ? (32'(low_power_reg) << LOW_POWER_POS) :
        hit(reg_addr, OFS_CTRL_STAT) ? (32'(mclk_ready_reg) << MCLK_READY_POS) :
        hit(reg_addr, OFS_PW_STAT) ? widen(pw_en_reg) :
        hit(reg_addr, OFS_PW_ACT) ? widen(activity) :
        hit(reg_addr, OFS_PW_GLOBAL) ? (32'(|activity) << ACTIVITY_POS) :
        hit(reg_addr, OFS_TICK_CAL) ? TICK_CAL_VALUE :
        32'h00000000;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_read ? read_mux : 32'h00000000;
    end

endmodule

/* File: src/pcg_pkg.sv */
// Package for the power and clock gating controller: register map, field layouts,
// reset values and timing constants.
// Assumes a single 50 MHz system clock and a word-aligned 32-bit register port.
package pcg_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_SYS_CLK_EN = 8'h00;
    localparam logic [7:0] OFS_SYS_CLK_DIS = 8'h04;
    localparam logic [7:0] OFS_SYS_CLK_STAT = 8'h08;
    localparam logic [7:0] OFS_PER_CLK_EN = 8'h10;
    localparam logic [7:0] OFS_PER_CLK_DIS = 8'h14;
    localparam logic [7:0] OFS_PER_CLK_STAT = 8'h18;
    localparam logic [7:0] OFS_MCLK_CFG = 8'h20;
    localparam logic [7:0] OFS_USB_CFG = 8'h24;
    localparam logic [7:0] OFS_FAST_START = 8'h28;
    localparam logic [7:0] OFS_CTRL_STAT = 8'h2C;
    localparam logic [7:0] OFS_PW_EN = 8'h30;
    localparam logic [7:0] OFS_PW_DIS = 8'h34;
    localparam logic [7:0] OFS_PW_STAT = 8'h38;
    localparam logic [7:0] OFS_PW_ACT = 8'h3C;
    localparam logic [7:0] OFS_PW_GLOBAL = 8'h40;
    localparam logic [7:0] OFS_TICK_CAL = 8'h44;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int USB_CLOCK_BIT_POS = 5;
    localparam int SRC_SEL_LSB = 0;
    localparam int DIV_SEL_LSB = 4;
    localparam int USB_SEL_POS = 0;
    localparam int USB_DIV_LSB = 8;
    localparam int LOW_POWER_POS = 20;
    localparam int MCLK_READY_POS = 3;
    localparam int ACTIVITY_POS = 0;

    // ****************************************
    // Encodings and reset values
    // ****************************************
    localparam logic [1:0] SRC_SLOW = 2'h0;
    localparam logic [1:0] SRC_MAIN_RC = 2'h1;
    localparam logic [1:0] SRC_FIRST_PLL = 2'h2;
    localparam logic [1:0] SRC_USB_PLL = 2'h3;
    localparam logic [2:0] DIV_SEL_DIV3 = 3'h7;
    localparam logic [2:0] DIV_SEL_RESET = 3'h0;
    localparam logic [1:0] RC_FREQ_4MHZ = 2'h0;
    localparam logic [31:0] TICK_CAL_VALUE = 32'h0000927C; // 37500

    typedef struct packed {
        logic [1:0] src_sel;
        logic [2:0] div_sel;
    } pcg_mclk_cfg_t;

    typedef struct packed {
        logic usb_sel;
        logic [3:0] usb_div;
    } pcg_usb_cfg_t;

    localparam pcg_mclk_cfg_t MCLK_CFG_RESET = '{src_sel: SRC_MAIN_RC, div_sel: DIV_SEL_RESET};

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 50;
    localparam int MCLK_SWITCH_NS = 200;
    localparam int MCLK_SWITCH_CYCLES = (MCLK_SWITCH_NS * CLK_MHZ + 999) / 1000;

endpackage

/* File: bench/pcg_periph_model.sv */
// Peripheral side: clock and wake requests of each peripheral.
// Assumes the bench commands it; outputs are asynchronous levels.
`timescale 1ns/1ps
module pcg_periph_model #(
    parameter int NUM_PERIPH = 8
)
(
    input wire logic [NUM_PERIPH-1:0] req_cmd,
    input wire logic [NUM_PERIPH-1:0] wake_cmd,
    output logic [NUM_PERIPH-1:0] clk_req,
    output logic [NUM_PERIPH-1:0] wake_req
);
    // ****
    // Requests
    // ****
    initial
    begin
        clk_req = '0;
        wake_req = '0;
    end
    // Skew off the clock edge so the synchronisers see a truly async level
    always @(req_cmd) clk_req <= #7 req_cmd;
    // Wake only rides on a standing request: conditions met
    always @(req_cmd, wake_cmd) wake_req <= #7 req_cmd & wake_cmd;
endmodule

/* File: bench/pcg_ctrl_checker.sv */
// Port-level timing relations of the clock gating controller.
// Assumes it is bound to pcg_ctrl and sees only its ports.
`timescale 1ns/1ps
module pcg_ctrl_checker
    import pcg_pkg::*;
#(
    parameter int NUM_PERIPH = 32
)
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic core_instr_done,
    input wire logic irq_wake,
    input wire logic wait_mode,
    input wire pcg_pkg::pcg_mclk_cfg_t master_clock_cfg,
    input wire logic [1:0] main_rc_freq_sel,
    input wire logic master_clock_ready,
    input wire logic cpu_clock_en,
    input wire logic bus_clock_en,
    input wire logic usb_clock_en,
    input wire logic [NUM_PERIPH-1:0] periph_clock_en
);
    // ****
    // Assertions
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_rdata_only_read: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data outside its slot");
    a_tick_cal_const: assert property (reg_read && reg_addr[7:2] == OFS_TICK_CAL[7:2]
        |=> reg_rdata == TICK_CAL_VALUE) else $error("tick calibration wrong");
    a_ready_clear_write: assert property (reg_write && reg_addr[7:2] == OFS_MCLK_CFG[7:2]
        |=> !master_clock_ready) else $error("ready not cleared by config write");
    a_cfg_follows_write: assert property (reg_write && reg_addr[7:2] == OFS_MCLK_CFG[7:2]
        |=> master_clock_cfg == {$past(reg_wdata[1:0]), $past(reg_wdata[6:4])}) else $error("config not taken");
    a_rc_freq_fixed: assert property (main_rc_freq_sel == RC_FREQ_4MHZ)
        else $error("rc frequency not 4 MHz");
    a_bus_keeps_running: assert property (bus_clock_en == !wait_mode)
        else $error("bus clock gated in sleep");
    a_irq_wakes_cpu: assert property (irq_wake |=> cpu_clock_en || wait_mode)
        else $error("interrupt did not restart core");
    a_stop_after_done: assert property ($fell(cpu_clock_en) && !wait_mode |-> $past(core_instr_done))
        else $error("core stopped mid instruction");
    a_disable_at_once: assert property (reg_write && reg_addr[7:2] == OFS_PER_CLK_DIS[7:2]
        |=> (periph_clock_en & $past(reg_wdata[NUM_PERIPH-1:0])) == '0) else $error("gate still open");
    a_usb_off_wait: assert property (wait_mode |-> !usb_clock_en)
        else $error("usb clock in wait mode");
    a_cpu_off_wait: assert property (wait_mode |-> !cpu_clock_en)
        else $error("core clock in wait mode");
endmodule

/* File: bench/pcg_ctrl_tb.sv */
// Self-checking bench for the clock gating controller.
// Assumes pcg_pkg, pcg_ctrl, the peripheral model and the checker are compiled first.
`timescale 1ns/1ps
module pcg_ctrl_tb import pcg_pkg::*;;
    // ****
    // Signals and instances
    // ****
    localparam int NP = 8;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0, reg_read = 1'b0, core_wfi = 1'b0, core_wfe = 1'b0;
    logic core_instr_done = 1'b0, irq_wake = 1'b0, wait_mode = 1'b0;
    logic [NP-1:0] req_cmd = '0, wake_cmd = '0, clk_req, wake_req, periph_clock_en;
    logic [31:0] reg_rdata;
    pcg_mclk_cfg_t master_clock_cfg;
    pcg_usb_cfg_t usb_cfg;
    logic [1:0] main_rc_freq_sel;
    logic [3:0] src_ready = 4'hF;
    logic master_clock_tick, master_clock_ready, cpu_clock_en, bus_clock_en, usb_clock_en, system_wake;
    int num_errors = 0;
    int comparisons = 0;
    int n;

    always #10 clk = ~clk;

    // Short switch count keeps the ready wait brief
    pcg_ctrl #(.NUM_PERIPH(NP), .SWITCH_CYCLES(1)) i_pcg_ctrl (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .source_ready_async(src_ready), .core_wfi(core_wfi), .core_wfe(core_wfe),
        .core_instr_done(core_instr_done), .irq_wake(irq_wake), .wait_mode(wait_mode),
        .periph_clk_req_async(clk_req), .periph_wake_req_async(wake_req),
        .master_clock_cfg(master_clock_cfg), .main_rc_freq_sel(main_rc_freq_sel),
        .master_clock_tick(master_clock_tick), .master_clock_ready(master_clock_ready),
        .cpu_clock_en(cpu_clock_en), .bus_clock_en(bus_clock_en), .usb_cfg(usb_cfg),
        .usb_clock_en(usb_clock_en), .periph_clock_en(periph_clock_en), .system_wake(system_wake));
    pcg_periph_model #(.NUM_PERIPH(NP)) i_pcg_periph_model (.req_cmd(req_cmd), .wake_cmd(wake_cmd),
        .clk_req(clk_req), .wake_req(wake_req));

    // ****
    // Tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic settle;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic wait_for(ref logic s);
        n = 0;
        while (s !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1 n++;
        end
        if (s !== 1'b1)
            num_errors++;
    endtask
    task automatic wake_seq(input logic [NP-1:0] m);
        @(posedge clk);
        req_cmd <= m;
        wake_cmd <= m;
        wait_for(system_wake);
        chk(system_wake, 32'h1);
        rd(OFS_PW_STAT, 32'h0);
    endtask
    task automatic tally_and_finish;
        $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ****
    // Tests
    // ****
    initial
    begin
        #(20 * 20000);
        num_errors++;
        $display("watchdog expired");
        tally_and_finish;
    end

    initial
    begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1 chk(master_clock_cfg, MCLK_CFG_RESET);
        chk(cpu_clock_en, 32'h1);
        chk(periph_clock_en, 32'h0);
        rd(OFS_TICK_CAL, TICK_CAL_VALUE);
        rd(OFS_PER_CLK_STAT, 32'h0);
        rd(8'hFC, 32'h0);
        $display("reset test done");
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_MCLK_CFG, (i << 4) | (i % 4));
            #1 chk(master_clock_ready, 32'h0);
            chk(master_clock_cfg, (i % 4) * 8 + i);
            wait_for(master_clock_ready);
            rd(OFS_CTRL_STAT, 32'h8);
            wait_for(master_clock_tick);
            @(posedge clk);
            #1 wait_for(master_clock_tick);
            chk(n + 1, i == 7 ? 3 : 1 << i);
        end
        // First PLL not ready: the flag must wait for it, not only for the counter
        src_ready <= 4'hB;
        wr(OFS_MCLK_CFG, 32'h2);
        settle;
        chk(master_clock_ready, 32'h0);
        rd(OFS_CTRL_STAT, 32'h0);
        src_ready <= 4'hF;
        settle;
        chk(master_clock_ready, 32'h1);
        $display("master clock test done");
        wr(OFS_PER_CLK_EN, 32'hA5);
        rd(OFS_PER_CLK_STAT, 32'hA5);
        chk(periph_clock_en, 32'hA5);
        wr(OFS_PER_CLK_DIS, 32'h21);
        #1 chk(periph_clock_en, 32'h84);
        rd(OFS_PER_CLK_STAT, 32'h84);
        wr(OFS_PER_CLK_EN, 32'hFF);
        wr(OFS_USB_CFG, 32'h501);
        rd(OFS_USB_CFG, 32'h501);
        chk(usb_cfg, 32'h15);
        wr(OFS_SYS_CLK_EN, 32'h20);
        #1 chk(usb_clock_en, 32'h1);
        rd(OFS_SYS_CLK_STAT, 32'h20);
        chk(periph_clock_en, 32'hFF);
        wr(OFS_SYS_CLK_DIS, 32'h20);
        #1 chk(usb_clock_en, 32'h0);
        $display("gate test done");
        for (int k = 0; k < 4; k++)
        begin
            wr(OFS_FAST_START, (k / 2) << LOW_POWER_POS);
            core_wfi <= (k % 2 == 0);
            core_wfe <= (k % 2 == 1);
            @(posedge clk);
            core_wfi <= 1'b0;
            core_wfe <= 1'b0;
            repeat (2) @(posedge clk);
            #1 chk(cpu_clock_en, 32'h1);
            @(posedge clk);
            core_instr_done <= 1'b1;
            @(posedge clk);
            core_instr_done <= 1'b0;
            @(posedge clk);
            #1 chk(cpu_clock_en, k < 2 ? 0 : 1);
            @(posedge clk);
            irq_wake <= 1'b1;
            @(posedge clk);
            irq_wake <= 1'b0;
            #1 chk(cpu_clock_en, 32'h1);
        end
        $display("sleep test done");
        wr(OFS_PW_EN, 32'h8);
        wr(OFS_PW_DIS, 32'h8);
        rd(OFS_PW_STAT, 32'h0);
        wr(OFS_PW_EN, 32'h4);
        settle;
        chk(periph_clock_en, 32'hFB);
        req_cmd <= 8'h04;
        settle;
        chk(periph_clock_en, 32'hFF);
        rd(OFS_PW_ACT, 32'h4);
        rd(OFS_PW_GLOBAL, 32'h1);
        req_cmd <= 8'h00;
        settle;
        chk(periph_clock_en, 32'hFB);
        wake_seq(8'h04);
        req_cmd <= 8'h00;
        wake_cmd <= 8'h00;
        settle;
        chk(periph_clock_en, 32'hFF);
        wr(OFS_PW_EN, 32'h2);
        wait_mode <= 1'b1;
        settle;
        chk(periph_clock_en, 32'h0);
        chk(cpu_clock_en, 32'h0);
        req_cmd <= 8'h02;
        settle;
        chk(periph_clock_en, 32'h2);
        req_cmd <= 8'h00;
        settle;
        chk(periph_clock_en, 32'h0);
        wake_seq(8'h02);
        $display("partial wake-up test done");
        tally_and_finish;
    end
endmodule

bind pcg_ctrl pcg_ctrl_checker #(.NUM_PERIPH(NUM_PERIPH)) i_pcg_ctrl_checker (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .core_instr_done(core_instr_done), .irq_wake(irq_wake), .wait_mode(wait_mode),
    .master_clock_cfg(master_clock_cfg), .main_rc_freq_sel(main_rc_freq_sel),
    .master_clock_ready(master_clock_ready), .cpu_clock_en(cpu_clock_en), .bus_clock_en(bus_clock_en),
    .usb_clock_en(usb_clock_en), .periph_clock_en(periph_clock_en));
